// ==== position_limit_polarity_objects.v ====
`timescale 1ns/1ps
`include "pos_limit_map.vh"
module position_limit_polarity_objects (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        arst_n,
   // Object access port
   input  wire        obj_wr,
   input  wire        obj_rd,
   input  wire [15:0] obj_index,
   input  wire [7:0]  obj_sub,
   input  wire [31:0] obj_wdata,
   output reg  [31:0] obj_rdata,
   output reg         obj_ack,
   output reg         obj_err,
   // Motion inputs
   input  wire [7:0]  mode,
   input  wire        closed_loop,
   input  wire [31:0] position_value,
   input  wire        target_valid,
   input  wire [31:0] target_position,
   input  wire [31:0] speed_request,
   input  wire [31:0] velocity_in,
   // Motion outputs
   output reg         range_overflow,
   output reg         target_accept,
   output reg         target_reject,
   output reg  [31:0] target_out,
   output reg  [31:0] speed_out,
   output reg         direction_reverse,
   output reg  [31:0] velocity_out,
   output reg         velocity_reverse_bit_out
);
   // ----------------------------------------
   // Parameter storage
   // ----------------------------------------
   reg [31:0] range_lower_bound_r;
   reg [31:0] range_upper_bound_r;
   reg [31:0] homing_offset_r;
   reg [31:0] soft_lower_limit_r;
   reg [31:0] soft_upper_limit_r;
   reg [7:0]  direction_reversal_r;
   reg [31:0] profile_speed_cap_r;
   // Read-only entry counts of the two array objects
   wire [7:0]  range_entry_count;
   wire [7:0]  soft_limit_entry_count;

   wire pos_below;
   wire pos_above;
   wire tgt_below;
   wire tgt_above;
   wire velocity_reverse_bit;
   wire position_reverse_bit;
   reg  [31:0] rdata_nxt;
   reg         hit_nxt;
   reg         rev_nxt;
   reg         cap_on;
   // Window results shared by the output flops
   wire        pos_out_of_range;
   wire        tgt_in_window;

   assign velocity_reverse_bit   = direction_reversal_r[`BIT_VELOCITY_REV];
   assign position_reverse_bit   = direction_reversal_r[`BIT_POSITION_REV];

   // Fixed entry counts of both arrays
   assign range_entry_count      = `ENTRY_COUNT;
   assign soft_limit_entry_count = `ENTRY_COUNT;
   assign pos_out_of_range       = pos_below | pos_above;
   assign tgt_in_window          = ~tgt_below & ~tgt_above;

   // Known object and subindex
   function valid_obj;
      input [15:0] idx;
      input [7:0]  sub;
      begin
         case (idx)
            `IDX_RANGE, `IDX_SOFT: valid_obj = (sub <= `SUB_MAX);
            `IDX_HOME, `IDX_POLARITY, `IDX_SPEED_CAP: valid_obj = (sub == `SUB_COUNT);
            default: valid_obj = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Comparators
   // ----------------------------------------
   limit_cmp u_range (
      .value (position_value),
      .lower (range_lower_bound_r),
      .upper (range_upper_bound_r),
      .below (pos_below),
      .above (pos_above)
   );

   // Raw target only, no offset added
   limit_cmp u_soft (
      .value (target_position),
      .lower (soft_lower_limit_r),
      .upper (soft_upper_limit_r),
      .below (tgt_below),
      .above (tgt_above)
   );

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always @* begin
      rdata_nxt = `ZERO32;
      hit_nxt   = valid_obj(obj_index, obj_sub);
      case (obj_index)
         `IDX_RANGE: begin
            if (obj_sub == `SUB_COUNT)
               rdata_nxt = {24'h000000, range_entry_count};
            else if (obj_sub == `SUB_MIN)
               rdata_nxt = range_lower_bound_r;
            else if (obj_sub == `SUB_MAX)
               rdata_nxt = range_upper_bound_r;
         end
         `IDX_SOFT: begin
            if (obj_sub == `SUB_COUNT)
               rdata_nxt = {24'h000000, soft_limit_entry_count};
            else if (obj_sub == `SUB_MIN)
               rdata_nxt = soft_lower_limit_r;
            else if (obj_sub == `SUB_MAX)
               rdata_nxt = soft_upper_limit_r;
         end
         `IDX_HOME:      rdata_nxt = homing_offset_r;
         `IDX_POLARITY:  rdata_nxt = {24'h000000, direction_reversal_r};
         `IDX_SPEED_CAP: rdata_nxt = profile_speed_cap_r;
         default:        rdata_nxt = `ZERO32;
      endcase
      if (!hit_nxt)
         rdata_nxt = `ZERO32;
   end

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   // Exact object and subindex match
   function obj_match;
      input [15:0] idx;
      input [7:0]  sub;
      input [15:0] want_idx;
      input [7:0]  want_sub;
      begin
         obj_match = (idx == want_idx) && (sub == want_sub);
      end
   endfunction

   // Access request, count write flag and write enables, one per writable register
   wire        obj_req;
   wire        count_wr;
   wire        wr_range_lower;
   wire        wr_range_upper;
   wire        wr_home;
   wire        wr_soft_lower;
   wire        wr_soft_upper;
   wire        wr_polarity;
   wire        wr_speed_cap;

   assign obj_req        = obj_wr | obj_rd;
   // Entry counts are read only; writes there only raise obj_err
   assign count_wr       = obj_wr & (obj_match(obj_index, obj_sub, `IDX_RANGE, `SUB_COUNT) |
                                     obj_match(obj_index, obj_sub, `IDX_SOFT, `SUB_COUNT));
   // Unknown objects never match, so they cannot write anything
   assign wr_range_lower = obj_wr & obj_match(obj_index, obj_sub, `IDX_RANGE, `SUB_MIN);
   assign wr_range_upper = obj_wr & obj_match(obj_index, obj_sub, `IDX_RANGE, `SUB_MAX);
   assign wr_home        = obj_wr & obj_match(obj_index, obj_sub, `IDX_HOME, `SUB_COUNT);
   assign wr_soft_lower  = obj_wr & obj_match(obj_index, obj_sub, `IDX_SOFT, `SUB_MIN);
   assign wr_soft_upper  = obj_wr & obj_match(obj_index, obj_sub, `IDX_SOFT, `SUB_MAX);
   assign wr_polarity    = obj_wr & obj_match(obj_index, obj_sub, `IDX_POLARITY, `SUB_COUNT);
   assign wr_speed_cap   = obj_wr & obj_match(obj_index, obj_sub, `IDX_SPEED_CAP, `SUB_COUNT);

   // ----------------------------------------
   // Parameter registers
   // ----------------------------------------
   // One process per register, so each enable sits beside its reset value
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         range_lower_bound_r <= `ZERO32;
      end else if (wr_range_lower) begin
         range_lower_bound_r <= obj_wdata;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         range_upper_bound_r <= `ZERO32;
      end else if (wr_range_upper) begin
         range_upper_bound_r <= obj_wdata;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         homing_offset_r <= `ZERO32;
      end else if (wr_home) begin
         homing_offset_r <= obj_wdata;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         soft_lower_limit_r <= `ZERO32;
      end else if (wr_soft_lower) begin
         soft_lower_limit_r <= obj_wdata;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         soft_upper_limit_r <= `ZERO32;
      end else if (wr_soft_upper) begin
         soft_upper_limit_r <= obj_wdata;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         direction_reversal_r <= `POLARITY_RST;
      end else if (wr_polarity) begin
         direction_reversal_r <= obj_wdata[7:0] & `POL_MASK;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         profile_speed_cap_r <= `SPEED_CAP_RST;
      end else if (wr_speed_cap) begin
         profile_speed_cap_r <= obj_wdata;
      end
   end

   // ----------------------------------------
   // Access answer
   // ----------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         obj_rdata <= `ZERO32;
         obj_ack   <= 1'b0;
         obj_err   <= 1'b0;
      end else begin
         obj_ack <= obj_req;
         // Refused accesses still answer, with the error flag set
         obj_err <= obj_req & (~hit_nxt | count_wr);
         // Read data holds between reads so a slow master can fetch it late
         if (obj_rd)
            obj_rdata <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Mode dependent direction and speed cap
   // ----------------------------------------
   always @* begin
      rev_nxt = 1'b0;
      cap_on  = 1'b0;
      case (mode)
         `MODE_PV, `MODE_CSV: rev_nxt = velocity_reverse_bit;
         `MODE_PP, `MODE_CSP: rev_nxt = position_reverse_bit;
         default: rev_nxt = 1'b0;
      endcase
      case (mode)
         `MODE_PP, `MODE_PV: cap_on = 1'b1;
         `MODE_IP:           cap_on = closed_loop;
         default:            cap_on = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Motion outputs
   // ----------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         range_overflow <= 1'b0;
         target_accept  <= 1'b0;
         target_reject  <= 1'b0;
         target_out     <= `ZERO32;
      end else begin
         // Level, not sticky: clears once the position is back in range
         range_overflow <= pos_out_of_range;
         target_accept  <= target_valid & tgt_in_window;
         target_reject  <= target_valid & ~tgt_in_window;
         // Last accepted target is held; rejected ones never reach the loop
         if (target_valid && tgt_in_window)
            target_out <= target_position;
      end
   end

   // ----------------------------------------
   // Speed and direction outputs
   // ----------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         speed_out                <= `ZERO32;
         direction_reverse        <= 1'b0;
         velocity_out             <= `ZERO32;
         velocity_reverse_bit_out <= 1'b0;
      end else begin
         // Outside the capped modes the request passes unchanged
         if (cap_on && speed_request > profile_speed_cap_r)
            speed_out <= profile_speed_cap_r;
         else
            speed_out <= speed_request;
         direction_reverse <= rev_nxt;
         // Negation wraps for the most negative value
         velocity_out <= rev_nxt ? (~velocity_in + 32'h00000001) : velocity_in;
         velocity_reverse_bit_out <= velocity_reverse_bit;
      end
   end
endmodule // position_limit_polarity_objects

// ==== pos_limit_map.vh ====
`ifndef POS_LIMIT_MAP_VH
`define POS_LIMIT_MAP_VH
// ----------------------------------------
// Object indices and subindices
// ----------------------------------------
`define IDX_RANGE        16'h607B
`define IDX_HOME         16'h607C
`define IDX_SOFT         16'h607D
`define IDX_POLARITY     16'h607E
`define IDX_SPEED_CAP    16'h607F
`define SUB_COUNT        8'h00
`define SUB_MIN          8'h01
`define SUB_MAX          8'h02
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define ENTRY_COUNT      8'h02
`define ZERO32           32'h00000000
`define POLARITY_RST     8'h00
`define SPEED_CAP_RST    32'h00007530
`define POL_MASK         8'hC0
`define BIT_VELOCITY_REV 6
`define BIT_POSITION_REV 7
// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define MODE_PP          8'h01
`define MODE_PV          8'h03
`define MODE_IP          8'h07
`define MODE_CSP         8'h08
`define MODE_CSV         8'h09
`endif

// ==== limit_cmp.v ====
`timescale 1ns/1ps
module limit_cmp (
   // Value and bounds, signed
   input  wire signed [31:0] value,
   input  wire signed [31:0] lower,
   input  wire signed [31:0] upper,
   // Results
   output wire               below,
   output wire               above
);
   assign below = value < lower;
   assign above = value > upper;
endmodule // limit_cmp

// ==== position_limit_polarity_objects_checker.sv ====
`timescale 1ns/1ps
module position_limit_polarity_objects_checker (
   input logic sys_clk, arst_n, obj_wr, obj_rd, obj_ack, obj_err,
   input logic [15:0] obj_index,
   input logic [7:0]  obj_sub, mode,
   input logic target_valid, target_accept, target_reject, direction_reverse,
   input logic [31:0] speed_request, speed_out, velocity_out,
   input logic signed [31:0] velocity_in
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_req; obj_wr || obj_rd; endsequence
   sequence s_cnt; obj_wr && obj_sub == 8'h00 && obj_index inside {16'h607B, 16'h607D}; endsequence
   property p_ack; s_req |=> obj_ack; endproperty
   property p_idle; !(obj_wr || obj_rd) |=> !obj_ack && !obj_err; endproperty
   property p_cnt; s_cnt |=> obj_err; endproperty
   property p_tgt; target_valid |=> target_accept != target_reject; endproperty
   property p_notgt; !target_valid |=> !target_accept && !target_reject; endproperty
   property p_norev; !(mode inside {8'h01, 8'h03, 8'h08, 8'h09}) |=> !direction_reverse; endproperty
   property p_free; mode == 8'h08 |=> speed_out == $past(speed_request); endproperty
   property p_cap; mode == 8'h01 |=> speed_out <= $past(speed_request); endproperty
   property p_vel;
      $past(arst_n) |-> velocity_out == (direction_reverse ? -$past(velocity_in) : $past(velocity_in));
   endproperty
   a_ack: assert property (p_ack) else $error("no ack after access");
   a_idle: assert property (p_idle) else $error("ack without access");
   a_cnt: assert property (p_cnt) else $error("count write not refused");
   a_tgt: assert property (p_tgt) else $error("target not judged once");
   a_notgt: assert property (p_notgt) else $error("stray target verdict");
   a_norev: assert property (p_norev) else $error("reversal in wrong mode");
   a_free: assert property (p_free) else $error("speed capped in CSP");
   a_cap: assert property (p_cap) else $error("speed raised above request");
   a_vel: assert property (p_vel) else $error("velocity sign wrong");
endmodule // position_limit_polarity_objects_checker

// ==== obj_master.sv ====
`timescale 1ns/1ps
module obj_master (
   input  logic        sys_clk,
   output logic        obj_wr, obj_rd,
   output logic [15:0] obj_index,
   output logic [7:0]  obj_sub,
   output logic [31:0] obj_wdata
);
   initial {obj_wr, obj_rd, obj_index, obj_sub, obj_wdata} = '0;
   // Idle bus shows inverted values so stale data cannot pass
   task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] d);
      @(posedge sys_clk) #1;
      {obj_wr, obj_rd, obj_index, obj_sub, obj_wdata} = {w, !w, i, s, d};
      @(posedge sys_clk) #1;
      {obj_wr, obj_rd, obj_index, obj_sub, obj_wdata} = {2'b00, ~i, ~s, ~d};
   endtask
endmodule // obj_master

// ==== position_limit_polarity_objects_tb_top.sv ====
`timescale 1ns/1ps
module position_limit_polarity_objects_tb_top;
   logic sys_clk, arst_n, obj_wr, obj_rd, obj_ack, obj_err, closed_loop, target_valid, rv, cp;
   logic range_overflow, target_accept, target_reject, direction_reverse, velocity_reverse_bit_out;
   logic [7:0]  obj_sub, mode;
   logic [15:0] obj_index;
   logic [31:0] obj_wdata, obj_rdata, position_value, target_position, speed_request, r;
   logic [31:0] target_out, speed_out, velocity_out, last_ok;
   logic signed [31:0] velocity_in;
   logic [33:0] aq[$], e;
   logic [32:0] tq[$], t;
   int err_count, n_tests, i, k;
   int tv[5] = '{-101, -100, 0, 100, 101};
   int pv[4] = '{-11, -10, 10, 11};
   logic [7:0] md[5] = '{8'h01, 8'h03, 8'h07, 8'h08, 8'h09};
   logic [55:0] tbl[9] = '{56'h607B_00_00000002, 56'h607B_01_00000000, 56'h607B_02_00000000,
      56'h607C_00_00000000, 56'h607D_00_00000002, 56'h607D_01_00000000,
      56'h607D_02_00000000, 56'h607E_00_00000000, 56'h607F_00_00007530};
   obj_master u_mst (.sys_clk, .obj_wr, .obj_rd, .obj_index, .obj_sub, .obj_wdata);
   position_limit_polarity_objects u_dut (.sys_clk, .arst_n, .obj_wr, .obj_rd, .obj_index,
      .obj_sub, .obj_wdata, .obj_rdata, .obj_ack, .obj_err, .mode, .closed_loop,
      .position_value, .target_valid, .target_position, .speed_request, .velocity_in,
      .range_overflow, .target_accept, .target_reject, .target_out, .speed_out,
      .direction_reverse, .velocity_out, .velocity_reverse_bit_out);
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic acc(input logic w, input logic [55:0] a, input logic x);
      aq.push_back({!w, x, a[31:0]});
      u_mst.acc(w, a[55:40], a[39:32], a[31:0]);
   endtask
   task automatic tgt(input logic [31:0] p, input logic a);
      if (a) last_ok = p;
      tq.push_back({a, last_ok});
      target_position = p;
      target_valid = 1'b1;
      @(posedge sys_clk) #1;
      target_valid = 1'b0;
      @(posedge sys_clk) #1;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      #2;
      if (obj_ack === 1'b1) begin
         e = aq.pop_front();
         chk("obj_err", e[32], obj_err);
         if (e[33]) chk("obj_rdata", e[31:0], obj_rdata);
      end
      if ((target_accept | target_reject) === 1'b1) begin
         t = tq.pop_front();
         chk("target_accept", t[32], target_accept);
         chk("target_reject", !t[32], target_reject);
         chk("target_out", t[31:0], target_out);
      end
   end
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #500000;
      err_count++;
      print_verdict();
   end
   initial begin
      {arst_n, mode, closed_loop, position_value, target_valid} = '0;
      {target_position, speed_request, velocity_in, err_count, n_tests, last_ok} = '0;
      r = $urandom(53);
      repeat (5) @(posedge sys_clk);
      #1 arst_n = 1'b1;
      foreach (tbl[k]) acc(0, tbl[k], 0);
      acc(1, 56'h607B_00_00000005, 1);
      acc(0, 56'h607D_00_00000002, 0);
      acc(0, 56'h6080_00_00000000, 1);
      acc(1, 56'h607E_00_000000FF, 0);
      acc(0, 56'h607E_00_000000C0, 0);
      r = $urandom;
      acc(1, {24'h607C_00, r}, 0);
      acc(0, {24'h607C_00, r}, 0);
      acc(1, 56'h607D_01_FFFFFF9C, 0);
      acc(1, 56'h607D_02_00000064, 0);
      acc(0, 56'h607D_01_FFFFFF9C, 0);
      foreach (tv[k]) tgt(tv[k], tv[k] >= -100 && tv[k] <= 100);
      acc(1, 56'h607B_01_FFFFFFF6, 0);
      acc(1, 56'h607B_02_0000000A, 0);
      acc(0, 56'h607B_02_0000000A, 0);
      foreach (pv[k]) begin
         position_value = pv[k];
         repeat (2) @(posedge sys_clk);
         #1 chk("range_overflow", pv[k] < -10 || pv[k] > 10, range_overflow);
      end
      acc(1, 56'h607F_00_000003E8, 0);
      acc(0, 56'h607F_00_000003E8, 0);
      for (i = 0; i < 4; i++) begin
         acc(1, {24'h607E_00, 24'h0, i[1:0], 6'h00}, 0);
         foreach (md[k]) begin
            mode = md[k];
            velocity_in = $urandom;
            speed_request = $urandom_range(2000);
            closed_loop = i[0];
            @(posedge sys_clk) #1;
            rv = (md[k] inside {8'h03, 8'h09} && i[0]) || (md[k] inside {8'h01, 8'h08} && i[1]);
            cp = md[k] inside {8'h01, 8'h03} || (md[k] == 8'h07 && closed_loop);
            chk("direction_reverse", rv, direction_reverse);
            chk("velocity_out", rv ? -velocity_in : velocity_in, velocity_out);
            chk("velocity_reverse_bit_out", i[0], velocity_reverse_bit_out);
            chk("speed_out", cp && speed_request > 1000 ? 1000 : speed_request, speed_out);
         end
      end
      repeat (3) @(posedge sys_clk);
      chk("pending", 0, aq.size() + tq.size());
      print_verdict();
   end
endmodule // position_limit_polarity_objects_tb_top
bind position_limit_polarity_objects position_limit_polarity_objects_checker u_chk (
   .sys_clk, .arst_n, .obj_wr, .obj_rd, .obj_ack, .obj_err, .obj_index, .obj_sub, .mode,
   .target_valid, .target_accept, .target_reject, .direction_reverse, .speed_request,
   .speed_out, .velocity_out, .velocity_in);
